// ===== bsdr_decode.sv
// address space decoder: areas, aliases, on-chip ram, cache and mode windows
`timescale 1ns/100ps
module bsdr_decode
   import bsdr_pkg::*;
(
   // address in
   input  wire logic [31:0] addr_i,
   // decode out
   output bsdr_region_t     region_o,
   output logic [2:0]       area_o,
   output logic             through_o
);
   logic [2:0] top;

   always_comb begin
      top       = addr_i[31:29];
      region_o  = RG_OTHER;
      area_o    = addr_i[AREA_LSB +: 3];
      through_o = (top == TOP_THROUGH);
      // both cached and cache-through tops share the area index, so they alias
      if ((top == TOP_CACHED || top == TOP_THROUGH) && addr_i[28:0] <= AREA_LAST) begin
         region_o = RG_AREA;
      end else if (addr_i[31:12] == PAGE_XRAM) begin
         region_o = RG_XRAM;
      end else if (addr_i[31:12] == PAGE_YRAM) begin
         region_o = RG_YRAM;
      end else if (top == TOP_PURGE && addr_i[28:0] <= AREA_LAST) begin
         region_o = RG_PURGE;
      end else if (top == TOP_TAG) begin
         region_o = RG_TAG;
      end else if (addr_i[31:12] == PAGE_DATA) begin
         region_o = RG_DATA;
      end else if (addr_i[31:12] == PAGE_SDMODE_0 || addr_i[31:12] == PAGE_SDMODE_1) begin
         region_o = RG_SDMODE;
      end
   end
endmodule

// ===== bsdr_ext_model.sv
// far-side model: external party that floats the bus
`timescale 1ns/100ps
module bsdr_ext_model (
   input  wire logic core_clk_i,
   input  wire logic hold_i,
   output logic      wait_n_o,
   output logic      float_o
);
   // float only counts with wait held low, so both move on one edge
   always @(posedge core_clk_i) begin
      wait_n_o <= !hold_i;
      float_o  <= hold_i;
   end
endmodule

// ===== bsdr_pkg.sv
// package: constants and types for bus space decoding and control registers
// Overview of operation
// - registers are 16 bits; 32-bit reads return zero in the upper half
// - 32-bit writes land only when the upper data half carries the key
// - 16-bit register accesses are reads; a 16-bit write changes nothing
// - 16-bit register accesses decode at the word address plus 2
// - five 32 Mbyte areas 0 to 4 sit consecutively from address zero
// - the cache-through region aliases the cached areas onto the same memory
// - area memory types: 0 burst ROM, 2 and 3 synchronous DRAM, 3 DRAM
// - area 2 synchronous DRAM always uses auto-precharge, never open banks
// - area 3 synchronous DRAM may keep banks active
// - two 4 kbyte on-chip RAM halves, X and Y, are decoded
// - purge, tag array and data array cache-control regions are decoded
// - two 4 kbyte windows set the synchronous DRAM mode register
// - lane strobes write ordinary space and mask synchronous DRAM bytes
// - DRAM gets one column strobe per byte lane, lane 3 most significant
// - two-bit master code: CPU, DMA, ethernet DMA, other
// - refresh request is signalled while the bus is released
// - on release strobes float; acknowledge, refresh and master code stay
// - float request with wait floats strobes without ending the cycle
// - area 3 select stays inactive when area 3 is DRAM
package bsdr_pkg;
   localparam int REG_COUNT = 10;
   localparam logic [31:0] OFF_WAIT_CONTROL_1       = 32'h0fff_ffe8;
   localparam logic [31:0] OFF_REFRESH_TIME_CONST   = 32'h0fff_fff8;
   localparam logic [31:0] OFF_WAIT_CONTROL_2       = 32'hffff_ffc0;
   localparam logic [31:0] OFF_WAIT_CONTROL_3       = 32'hffff_ffc4;
   localparam logic [31:0] OFF_BUS_CONTROL_1        = 32'hffff_ffe0;
   localparam logic [31:0] OFF_BUS_CONTROL_2        = 32'hffff_ffe4;
   localparam logic [31:0] OFF_MEMORY_IF_CONTROL    = 32'hffff_ffec;
   localparam logic [31:0] OFF_REFRESH_CTRL_STATUS  = 32'hffff_fff0;
   localparam logic [31:0] OFF_REFRESH_TIMER_COUNT  = 32'hffff_fff4;
   localparam logic [31:0] OFF_BUS_CONTROL_3        = 32'hffff_fffc;
   localparam logic [15:0] RST_WAIT_CONTROL_1       = 16'haaff;
   localparam logic [15:0] RST_REFRESH_TIME_CONST   = 16'h0000;
   localparam logic [15:0] RST_WAIT_CONTROL_2       = 16'h000b;
   localparam logic [15:0] RST_WAIT_CONTROL_3       = 16'h0000;
   localparam logic [15:0] RST_BUS_CONTROL_1        = 16'h03f0;
   localparam logic [15:0] RST_BUS_CONTROL_2        = 16'h00fc;
   localparam logic [15:0] RST_MEMORY_IF_CONTROL    = 16'h0000;
   localparam logic [15:0] RST_REFRESH_CTRL_STATUS  = 16'h0000;
   localparam logic [15:0] RST_REFRESH_TIMER_COUNT  = 16'h0000;
   localparam logic [15:0] RST_BUS_CONTROL_3        = 16'h0f00;
   localparam logic [31:0] REG_OFFSET [REG_COUNT] = '{
      OFF_WAIT_CONTROL_1, OFF_REFRESH_TIME_CONST, OFF_WAIT_CONTROL_2,
      OFF_WAIT_CONTROL_3, OFF_BUS_CONTROL_1, OFF_BUS_CONTROL_2,
      OFF_MEMORY_IF_CONTROL, OFF_REFRESH_CTRL_STATUS, OFF_REFRESH_TIMER_COUNT,
      OFF_BUS_CONTROL_3};
   localparam logic [15:0] REG_RESET [REG_COUNT] = '{
      RST_WAIT_CONTROL_1, RST_REFRESH_TIME_CONST, RST_WAIT_CONTROL_2,
      RST_WAIT_CONTROL_3, RST_BUS_CONTROL_1, RST_BUS_CONTROL_2,
      RST_MEMORY_IF_CONTROL, RST_REFRESH_CTRL_STATUS, RST_REFRESH_TIMER_COUNT,
      RST_BUS_CONTROL_3};
   localparam logic [3:0]  IDX_BUS_CONTROL_1 = 4'h4;
   localparam logic [31:0] HALF_ACCESS_STEP  = 32'h0000_0002;
   localparam logic [15:0] WRITE_KEY         = 16'ha55a;
   // bus control 1 fields
   localparam int BC1_BURST_ROM_POS = 11;
   localparam int BC1_MEM_TYPE_LSB  = 0;
   localparam logic [2:0] MEM_TYPE_A3_DRAM = 3'h2;
   // address map
   localparam logic [28:0] AREA_LAST      = 29'h09ff_ffff;
   localparam int          AREA_LSB       = 25;
   localparam logic [2:0]  TOP_CACHED     = 3'h0;
   localparam logic [2:0]  TOP_THROUGH    = 3'h1;
   localparam logic [2:0]  TOP_PURGE      = 3'h2;
   localparam logic [2:0]  TOP_TAG        = 3'h3;
   localparam logic [19:0] PAGE_XRAM      = 20'h1000e;
   localparam logic [19:0] PAGE_YRAM      = 20'h1001e;
   localparam logic [19:0] PAGE_DATA      = 20'hc0000;
   localparam logic [19:0] PAGE_SDMODE_0  = 20'hffff0;
   localparam logic [19:0] PAGE_SDMODE_1  = 20'hffff8;
   localparam logic [2:0]  AREA_0         = 3'h0;
   localparam logic [2:0]  AREA_2         = 3'h2;
   localparam logic [2:0]  AREA_3         = 3'h3;
   // master codes
   localparam logic [1:0] MID_CPU   = 2'h0;
   localparam logic [1:0] MID_DMA   = 2'h1;
   localparam logic [1:0] MID_EDMA  = 2'h2;
   localparam logic [1:0] MID_OTHER = 2'h3;
   // access qualifier bits
   localparam int QN = 12;
   localparam int Q_EXT = 0, Q_THROUGH = 1, Q_XRAM = 2, Q_YRAM = 3, Q_PURGE = 4;
   localparam int Q_TAG = 5, Q_DATA = 6, Q_SDMODE = 7, Q_RESERVED = 8;
   localparam int Q_AUTOPRE = 9, Q_BANKACT = 10, Q_BURSTROM = 11;
   typedef enum logic [3:0] {
      RG_AREA, RG_XRAM, RG_YRAM, RG_PURGE, RG_TAG, RG_DATA, RG_SDMODE, RG_OTHER
   } bsdr_region_t;
endpackage

// ===== bsdr_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module bsdr_sync
   import bsdr_pkg::*;
#(
   parameter int             W         = 1,
   parameter logic [W-1:0]   RESET_VAL = '0
) (
   // clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         rst_n_i,
   // pins and filtered levels
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
   logic [W-1:0] lvl_d;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         // stage one feeds only stage two
         always_comb begin
            lvl_d[g] = (s2_q[g] == s3_q[g]) ? s2_q[g] : lvl_q[g];
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         s1_q  <= RESET_VAL;
         s2_q  <= RESET_VAL;
         s3_q  <= RESET_VAL;
         lvl_q <= RESET_VAL;
      end else begin
         s1_q  <= pin_i;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign level_o = lvl_q;
endmodule

// ===== bsdr_top.sv
// bus state controller space decode, control registers and strobe pins
`timescale 1ns/100ps
module bsdr_top
   import bsdr_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // internal access port
   input  wire logic        cpu_req_i,
   input  wire logic        cpu_write_i,
   input  wire logic        cpu_size32_i,
   input  wire logic [31:0] cpu_addr_i,
   input  wire logic [31:0] cpu_wdata_i,
   input  wire logic [3:0]  cpu_lanes_i,
   output logic             cpu_ack_o,
   output logic [31:0]      cpu_rdata_o,
   // arbitration state
   input  wire logic        grant_cpu_i,
   input  wire logic        grant_dma_i,
   input  wire logic        grant_edma_i,
   input  wire logic        bus_release_i,
   input  wire logic        refresh_pending_i,
   input  wire logic        dma_acknowledge_1_i,
   // pins from outside
   input  wire logic        wait_n_i,
   input  wire logic        bus_float_request_i,
   // access qualifiers
   output logic             ext_access_o,
   output logic             cache_through_o,
   output logic             xram_select_o,
   output logic             yram_select_o,
   output logic             purge_select_o,
   output logic             tag_select_o,
   output logic             data_array_select_o,
   output logic             sdram_mode_select_o,
   output logic             reserved_access_o,
   output logic             auto_precharge_o,
   output logic             bank_active_o,
   output logic             burst_rom_o,
   // strobe pins
   output logic             area0_select_n_o,
   output logic             area1_select_n_o,
   output logic             area2_select_n_o,
   output logic             area3_select_n_o,
   output logic             area4_select_n_o,
   output logic             lane3_write_strobe_n_o,
   output logic             lane2_write_strobe_n_o,
   output logic             lane1_write_strobe_n_o,
   output logic             lane0_write_strobe_n_o,
   output logic             lane3_column_strobe_n_o,
   output logic             lane2_column_strobe_n_o,
   output logic             lane1_column_strobe_n_o,
   output logic             lane0_column_strobe_n_o,
   output logic             strobe_oe_o,
   // always-driven pins
   output logic [1:0]       master_id_out_o,
   output logic             refresh_request_out_o,
   output logic             dma_acknowledge_1_o
);
   typedef enum logic {ST_IDLE, ST_ACTIVE} bsdr_state_t;

   bsdr_state_t  state_q, state_d;
   logic         ack_q, ack_d;
   logic [31:0]  rdata_q, rdata_d;
   logic [4:0]   sel_n_q, sel_n_d;
   logic [3:0]   lane_q, lane_d;
   logic [3:0]   col_n_q, col_n_d;
   logic [QN-1:0] qual_q, qual_d;
   logic [15:0]  regs_q [REG_COUNT];
   logic [15:0]  regs_d [REG_COUNT];
   logic         oe_q, oe_d;
   logic         refresh_q, refresh_d;
   logic [1:0]   mid_q, mid_d;
   logic         dack_q, dack_d;

   bsdr_region_t dec_region;
   logic [2:0]   dec_area;
   logic         dec_through;
   logic         wait_n_s, float_s, float_active;
   logic         take, hit, key_ok, wr_en, is_ext;
   logic [3:0]   hit_idx;
   logic [2:0]   mem_type;
   logic         a2_sdram, a3_sdram, a3_dram, sdram_area, dram_area;
   logic [15:0]  sel_val;

   bsdr_decode u_decode (
      .addr_i    (cpu_addr_i),
      .region_o  (dec_region),
      .area_o    (dec_area),
      .through_o (dec_through)
   );

   bsdr_sync #(.W(2), .RESET_VAL(2'h1)) u_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .pin_i      ({bus_float_request_i, wait_n_i}),
      .level_o    ({float_s, wait_n_s})
   );

   // float only counts while the far side also holds wait
   assign float_active = float_s & ~wait_n_s;

   // register match; half-word accesses sit two bytes higher
   always_comb begin
      hit     = 1'b0;
      hit_idx = 4'h0;
      for (int i = 0; i < REG_COUNT; i++) begin
         if (cpu_size32_i ? (cpu_addr_i == REG_OFFSET[i])
                          : (cpu_addr_i == REG_OFFSET[i] + HALF_ACCESS_STEP)) begin
            hit     = 1'b1;
            hit_idx = 4'(i);
         end
      end
   end

   assign take    = (state_q == ST_IDLE) && cpu_req_i;
   assign key_ok  = (cpu_wdata_i[31:16] == WRITE_KEY);
   // half-word writes and keyless writes fall through silently
   assign wr_en   = take && hit && cpu_write_i && cpu_size32_i && key_ok;
   assign is_ext  = (dec_region == RG_AREA) && !hit;
   assign sel_val = regs_q[hit_idx];

   // memory type of areas 2 and 3 comes from bus control 1
   assign mem_type   = regs_q[IDX_BUS_CONTROL_1][BC1_MEM_TYPE_LSB +: 3];
   assign a2_sdram   = mem_type[2];
   assign a3_sdram   = mem_type[0];
   assign a3_dram    = (mem_type == MEM_TYPE_A3_DRAM);
   assign sdram_area = (dec_area == AREA_2 && a2_sdram) || (dec_area == AREA_3 && a3_sdram);
   assign dram_area  = (dec_area == AREA_3) && a3_dram;

   // access sequencing
   always_comb begin
      state_d = state_q;
      ack_d   = 1'b0;
      rdata_d = rdata_q;
      sel_n_d = sel_n_q;
      lane_d  = lane_q;
      col_n_d = col_n_q;
      qual_d  = qual_q;
      case (state_q)
         ST_IDLE: begin
            if (cpu_req_i) begin
               state_d = ST_ACTIVE;
               rdata_d = hit ? {16'h0000, sel_val} : 32'h0000_0000;
               qual_d  = '0;
               qual_d[Q_EXT]      = is_ext;
               qual_d[Q_THROUGH]  = is_ext && dec_through;
               qual_d[Q_XRAM]     = (dec_region == RG_XRAM);
               qual_d[Q_YRAM]     = (dec_region == RG_YRAM);
               qual_d[Q_PURGE]    = (dec_region == RG_PURGE);
               qual_d[Q_TAG]      = (dec_region == RG_TAG);
               qual_d[Q_DATA]     = (dec_region == RG_DATA);
               qual_d[Q_SDMODE]   = (dec_region == RG_SDMODE);
               qual_d[Q_RESERVED] = (dec_region == RG_OTHER) && !hit;
               if (is_ext) begin
                  qual_d[Q_AUTOPRE]  = (dec_area == AREA_2) && a2_sdram;
                  qual_d[Q_BANKACT]  = (dec_area == AREA_3) && a3_sdram;
                  qual_d[Q_BURSTROM] = (dec_area == AREA_0) &&
                                       regs_q[IDX_BUS_CONTROL_1][BC1_BURST_ROM_POS];
                  // dram on area 3 runs from the column strobes alone
                  if (!dram_area) begin
                     sel_n_d[dec_area] = 1'b0;
                  end
                  if (sdram_area) begin
                     lane_d = ~cpu_lanes_i;
                  end else if (cpu_write_i && !dram_area) begin
                     lane_d = ~cpu_lanes_i;
                  end
                  if (dram_area) begin
                     col_n_d = ~cpu_lanes_i;
                  end
               end
            end
         end
         ST_ACTIVE: begin
            // an external cycle freezes while its pins are floated
            if (!(qual_q[Q_EXT] && (float_active || bus_release_i))) begin
               state_d = ST_IDLE;
               ack_d   = 1'b1;
               sel_n_d = '1;
               lane_d  = '1;
               col_n_d = '1;
               qual_d  = '0;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         ack_q   <= 1'b0;
         rdata_q <= 32'h0000_0000;
         sel_n_q <= 5'h1f;
         lane_q  <= 4'hf;
         col_n_q <= 4'hf;
         qual_q  <= '0;
      end else begin
         state_q <= state_d;
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
         sel_n_q <= sel_n_d;
         lane_q  <= lane_d;
         col_n_q <= col_n_d;
         qual_q  <= qual_d;
      end
   end

   // control registers
   always_comb begin
      regs_d = regs_q;
      if (wr_en) begin
         regs_d[hit_idx] = cpu_wdata_i[15:0];
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         regs_q <= REG_RESET;
      end else begin
         regs_q <= regs_d;
      end
   end

   // pin drivers; acknowledge, refresh and master code never float
   always_comb begin
      oe_d      = !(bus_release_i || float_active);
      refresh_d = bus_release_i && refresh_pending_i;
      dack_d    = dma_acknowledge_1_i;
      if (grant_cpu_i) begin
         mid_d = MID_CPU;
      end else if (grant_dma_i) begin
         mid_d = MID_DMA;
      end else if (grant_edma_i) begin
         mid_d = MID_EDMA;
      end else begin
         mid_d = MID_OTHER;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         oe_q      <= 1'b0;
         refresh_q <= 1'b0;
         mid_q     <= MID_CPU;
         dack_q    <= 1'b0;
      end else begin
         oe_q      <= oe_d;
         refresh_q <= refresh_d;
         mid_q     <= mid_d;
         dack_q    <= dack_d;
      end
   end

   assign cpu_ack_o               = ack_q;
   assign cpu_rdata_o             = rdata_q;
   assign ext_access_o            = qual_q[Q_EXT];
   assign cache_through_o         = qual_q[Q_THROUGH];
   assign xram_select_o           = qual_q[Q_XRAM];
   assign yram_select_o           = qual_q[Q_YRAM];
   assign purge_select_o          = qual_q[Q_PURGE];
   assign tag_select_o            = qual_q[Q_TAG];
   assign data_array_select_o     = qual_q[Q_DATA];
   assign sdram_mode_select_o     = qual_q[Q_SDMODE];
   assign reserved_access_o       = qual_q[Q_RESERVED];
   assign auto_precharge_o        = qual_q[Q_AUTOPRE];
   assign bank_active_o           = qual_q[Q_BANKACT];
   assign burst_rom_o             = qual_q[Q_BURSTROM];
   assign {area4_select_n_o, area3_select_n_o, area2_select_n_o,
           area1_select_n_o, area0_select_n_o} = sel_n_q;
   assign {lane3_write_strobe_n_o, lane2_write_strobe_n_o,
           lane1_write_strobe_n_o, lane0_write_strobe_n_o} = lane_q;
   assign {lane3_column_strobe_n_o, lane2_column_strobe_n_o,
           lane1_column_strobe_n_o, lane0_column_strobe_n_o} = col_n_q;
   assign strobe_oe_o             = oe_q;
   assign master_id_out_o         = mid_q;
   assign refresh_request_out_o   = refresh_q;
   assign dma_acknowledge_1_o     = dack_q;

   // checks
   logic [16*REG_COUNT-1:0] regs_flat;
   always_comb begin
      for (int i = 0; i < REG_COUNT; i++) begin
         regs_flat[16*i +: 16] = regs_q[i];
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_bad_key;
      take && hit && cpu_write_i && cpu_size32_i && !key_ok;
   endsequence

   chk_upper_zero: assert property (cpu_ack_o |-> cpu_rdata_o[31:16] == 16'h0000)
      else $error("upper read half not zero");
   chk_key_reject: assert property (s_bad_key |=> $stable(regs_flat))
      else $error("keyless write changed a register");
   chk_half_nowrite: assert property (take && hit && cpu_write_i && !cpu_size32_i
      |=> $stable(regs_flat)) else $error("half-word write changed a register");
   chk_half_read: assert property (take && hit && !cpu_write_i && !cpu_size32_i
      |=> cpu_rdata_o == {16'h0000, $past(sel_val)} ##1 cpu_ack_o)
      else $error("half-word read wrong");
   chk_area_alias: assert property (take && is_ext && dec_area == AREA_0
      |=> !area0_select_n_o && cache_through_o == $past(dec_through))
      else $error("area 0 select or alias wrong");
   chk_dram_cs3: assert property (take && is_ext && dram_area
      |=> area3_select_n_o && col_n_q == ~$past(cpu_lanes_i))
      else $error("dram area select or column strobes wrong");
   chk_auto_pre: assert property (take && is_ext && dec_area == AREA_2 && a2_sdram
      |=> auto_precharge_o && !bank_active_o) else $error("area 2 bank left open");
   chk_lane_write: assert property (take && is_ext && cpu_write_i && !sdram_area
      && !dram_area |=> lane_q == ~$past(cpu_lanes_i)) else $error("write strobes wrong");
   chk_master_code: assert property (grant_edma_i && !grant_cpu_i && !grant_dma_i
      |=> master_id_out_o == MID_EDMA) else $error("master code wrong");
   chk_refresh_out: assert property (bus_release_i && refresh_pending_i
      |=> refresh_request_out_o) else $error("refresh request missing");
   chk_release_float: assert property (bus_release_i |=> !strobe_oe_o)
      else $error("strobes driven while released");
   chk_float_hold: assert property (state_q == ST_ACTIVE && qual_q[Q_EXT] && float_active
      |=> !cpu_ack_o && !strobe_oe_o) else $error("cycle ended while floated");
   chk_reject_ack: assert property (s_bad_key |=> ##1 cpu_ack_o)
      else $error("keyless write not acknowledged");
endmodule

// ===== tb.sv
// self-checking bench for space decode and control registers
`timescale 1ns/100ps
module tb
   import bsdr_pkg::*;
;
   logic clk = 0, rst_n = 0, req = 0, wr = 0, sz = 0, hold = 0;
   logic gc = 0, gd = 0, ge = 0, rel = 0, pend = 0, dk = 0;
   logic [31:0] addr = 0, wd = 0, rd;
   logic [3:0]  ln = 0, s_ws, s_cs;
   wire  [3:0]  ws, cs;
   logic        ack, wn, fl, oe, rf, dko;
   logic [1:0]  mid;
   logic [4:0]  s_sel;
   wire  [4:0]  sel;
   logic [11:0] s_q;
   wire  [11:0] q;
   logic [15:0] bcv [3] = '{16'h0000, 16'h0802, 16'h0005};
   logic [31:0] ra [8] = '{32'h1000_e004, 32'h1001_e008, 32'h4000_0010, 32'h6000_0020,
                           32'hc000_0ff0, 32'hffff_0040, 32'hffff_8ffc, 32'h0a00_0000};
   int rq [8] = '{Q_XRAM, Q_YRAM, Q_PURGE, Q_TAG, Q_DATA, Q_SDMODE, Q_SDMODE, Q_RESERVED};
   int fails = 0, n_checks = 0, seed = 32'hdfff23a4, m [REG_COUNT];
   always #5 clk = ~clk;
   bsdr_ext_model i_bsdr_ext_model (.core_clk_i(clk), .hold_i(hold), .wait_n_o(wn), .float_o(fl));
   bsdr_top i_bsdr_top (.core_clk_i(clk), .rst_n_i(rst_n), .cpu_req_i(req), .cpu_write_i(wr),
      .cpu_size32_i(sz), .cpu_addr_i(addr), .cpu_wdata_i(wd), .cpu_lanes_i(ln),
      .cpu_ack_o(ack), .cpu_rdata_o(rd), .grant_cpu_i(gc), .grant_dma_i(gd),
      .grant_edma_i(ge), .bus_release_i(rel), .refresh_pending_i(pend),
      .dma_acknowledge_1_i(dk), .wait_n_i(wn), .bus_float_request_i(fl),
      .ext_access_o(q[0]), .cache_through_o(q[1]), .xram_select_o(q[2]),
      .yram_select_o(q[3]), .purge_select_o(q[4]), .tag_select_o(q[5]),
      .data_array_select_o(q[6]), .sdram_mode_select_o(q[7]), .reserved_access_o(q[8]),
      .auto_precharge_o(q[9]), .bank_active_o(q[10]), .burst_rom_o(q[11]),
      .area0_select_n_o(sel[0]), .area1_select_n_o(sel[1]), .area2_select_n_o(sel[2]),
      .area3_select_n_o(sel[3]), .area4_select_n_o(sel[4]),
      .lane3_write_strobe_n_o(ws[3]), .lane2_write_strobe_n_o(ws[2]),
      .lane1_write_strobe_n_o(ws[1]), .lane0_write_strobe_n_o(ws[0]),
      .lane3_column_strobe_n_o(cs[3]), .lane2_column_strobe_n_o(cs[2]),
      .lane1_column_strobe_n_o(cs[1]), .lane0_column_strobe_n_o(cs[0]),
      .strobe_oe_o(oe), .master_id_out_o(mid), .refresh_request_out_o(rf),
      .dma_acknowledge_1_o(dko));
   task automatic test_done;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(logic [31:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // request held only through the take edge; snapshot the active phase
   task automatic acc(logic w, s, logic [31:0] a, d, logic [3:0] l);
      int n;
      @(posedge clk);
      {req, wr, sz, addr, wd, ln} <= {1'b1, w, s, a, d, l};
      @(posedge clk);
      req <= 1'b0;
      #1 {s_sel, s_ws, s_cs, s_q} = {sel, ws, cs, q};
      n = 0;
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      if (n == 20) fails++;
   endtask
   task automatic reg_op(int i, logic w, s, logic [31:0] d);
      acc(w, s, REG_OFFSET[i] + (s ? 32'h0 : HALF_ACCESS_STEP), d, 4'hf);
      if (w && s && d[31:16] == WRITE_KEY) m[i] = d[15:0];
      if (!w) chk(rd, 32'(m[i]));
   endtask
   task automatic ext(logic w, logic [31:0] a, logic [15:0] bc);
      logic [2:0] ar;
      logic       sd, dr;
      logic [3:0] l;
      ar = a[27:25];
      l = 4'($random(seed));
      sd = (ar == 3'h2 && bc[2]) || (ar == 3'h3 && bc[0]);
      dr = ar == 3'h3 && bc[2:0] == MEM_TYPE_A3_DRAM;
      acc(w, 1'b1, a, $random(seed), l);
      chk(s_sel, dr ? 5'h1f : 5'(~(5'h1 << ar)));
      chk(s_cs, dr ? 4'(~l) : 4'hf);
      chk(s_ws, (sd || (w && !dr)) ? 4'(~l) : 4'hf);
      chk(s_q, {ar == 0 && bc[11], ar == 3 && bc[0], ar == 2 && sd, 7'h0, a[29],
                1'b1});
   endtask
   initial begin
      for (int i = 0; i < REG_COUNT; i++) m[i] = REG_RESET[i];
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < REG_COUNT; i++) begin
         reg_op(i, 0, 1, 0);
         reg_op(i, 1, 1, {WRITE_KEY, 16'($random(seed))});
         reg_op(i, 1, 1, {~WRITE_KEY, 16'h1234});
         reg_op(i, 1, 0, 32'h0000_5678);
         reg_op(i, 0, 0, 0);
      end
      foreach (bcv[k]) begin
         reg_op(IDX_BUS_CONTROL_1, 1, 1, {WRITE_KEY, bcv[k]});
         for (int a = 0; a < 10; a++)
            ext(1'(k + a), {2'b00, 1'(a / 5), 1'b0, 3'(a % 5), 25'($random(seed))}, bcv[k]);
      end
      foreach (ra[k]) begin
         acc(1'b0, 1'b1, ra[k], 0, 4'hf);
         chk(s_q, 12'h1 << rq[k]);
      end
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {gc, gd, ge} <= i < 3 ? 3'b100 >> i : 3'b000;
         {rel, pend, dk} <= 3'(i + 3);
         repeat (3) @(posedge clk);
         #1 chk({mid, rf, dko, oe}, {2'(i), rel & pend, dk, ~rel});
      end
      @(posedge clk);
      {rel, hold} <= 2'b01;
      repeat (8) @(posedge clk);
      #1 chk(oe, 0);
      // an area 1 cycle started under float must freeze, not end
      @(posedge clk);
      {req, wr, sz, addr} <= {1'b1, 1'b0, 1'b1, 32'h0200_0000};
      @(posedge clk);
      req <= 1'b0;
      repeat (8) @(posedge clk);
      #1 chk({ack, sel[1], oe}, 3'b000);
      @(posedge clk);
      hold <= 1'b0;
      for (int j = 0; j < 20 && ack !== 1'b1; j++) begin
         @(posedge clk);
         #1;
      end
      chk({ack, oe}, 2'b11);
      repeat (8) @(posedge clk);
      #1 chk(oe, 1);
      test_done;
   end
   initial begin
      #200000;
      fails++;
      test_done;
   end
endmodule
